//--- hw/lpr_pkg.sv
/*
 * Shared definitions of the low-power and reset-state controller: register
 * indices, reset values, bus and wake-source carriers, sequencer states.
 * Assumes an AXI4-Lite master with 32-bit data and a 12-bit byte address.
 */
`default_nettype none

package lpr_pkg;

	// ------------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam logic [7:0] LPR_IDX_CTRL     = 8'h40; // Local control
	localparam logic [7:0] LPR_IDX_STAT     = 8'h41; // Local status
	localparam logic [7:0] LPR_IDX_BANK     = 8'hC0; // First mirrored index
	localparam logic [7:0] LPR_IDX_PORT_DAT = 8'hC0; // Port data C0..C2
	localparam logic [7:0] LPR_IDX_PORT_DIR = 8'hC4; // Port direction C4..C6
	localparam logic [7:0] LPR_IDX_INT_OPT  = 8'hC8; // Interrupt option
	localparam logic [7:0] LPR_IDX_PORT_OPT = 8'hCC; // Port option CC..CE
	localparam logic [7:0] LPR_IDX_ADC_CTRL = 8'hD1; // Converter control
	localparam logic [7:0] LPR_IDX_T1_PRESC = 8'hD2; // Timer prescaler
	localparam logic [7:0] LPR_IDX_T1_COUNT = 8'hD3; // Timer counter
	localparam logic [7:0] LPR_IDX_T1_STAT  = 8'hD4; // Timer status
	localparam logic [7:0] LPR_IDX_AR_MODE  = 8'hD5; // Auto-reload mode
	localparam logic [7:0] LPR_IDX_AR_STAT1 = 8'hD6; // Auto-reload status 1
	localparam logic [7:0] LPR_IDX_AR_STAT2 = 8'hD7; // Auto-reload status 2
	localparam logic [7:0] LPR_IDX_WDG_CNT  = 8'hD8; // Watchdog counter
	localparam logic [7:0] LPR_IDX_AR_CMP   = 8'hDA; // Auto-reload compare
	localparam logic [7:0] LPR_IDX_OSC_CTRL = 8'hDC; // Oscillator control
	localparam logic [7:0] LPR_IDX_MISC     = 8'hDD; // Miscellaneous
	localparam logic [7:0] LPR_IDX_SPI      = 8'hE0; // Serial E0..E2
	localparam logic [7:0] LPR_IDX_EE_CTRL  = 8'hEA; // EEPROM control

	// ------------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------------
	localparam logic [7:0] LPR_RST_CLEAR    = 8'h00; // Cleared registers
	localparam logic [7:0] LPR_RST_T1_COUNT = 8'hFF; // Maximum count
	localparam logic [7:0] LPR_RST_T1_PRESC = 8'h7F; // Prescaler start
	localparam logic [7:0] LPR_RST_WDG_CNT  = 8'hFE; // Watchdog counter
	localparam logic [7:0] LPR_RST_ADC_CTRL = 8'h40; // Converter standby
	localparam int         LPR_OSC_LOWPWR   = 3;     // Low-power bit
	localparam int         LPR_MISC_SPI_PC3 = 0;     // Serial to port C3
	localparam int         LPR_CTRL_DEEP_EN = 0;     // Deep stop allowed
	localparam int         LPR_STAB_CYCLES  = 2048;  // Oscillator settling
	localparam logic [1:0] LPR_RESP_OKAY    = 2'h0;  // Bus answer okay
	localparam logic [1:0] LPR_RESP_SLVERR  = 2'h2;  // Unmapped address

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		LPR_RUN  = 4'h1,
		LPR_IDLE = 4'h2,
		LPR_DEEP = 4'h4,
		LPR_STAB = 4'h8
	} lpr_mode_t;

	typedef enum logic [1:0] {
		LPR_CORE_MAIN = 2'h0,
		LPR_CORE_IRQ  = 2'h1,
		LPR_CORE_NMI  = 2'h2
	} lpr_core_mode_t;

	typedef struct packed {
		logic [11:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [11:0] araddr;
		logic        arvalid;
		logic        rready;
	} lpr_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} lpr_axi_rsp_t;

	typedef struct packed {
		logic timer1;    // First timer
		logic artimer;   // Auto-reload timer
		logic adc;       // Converter end
		logic spi;       // Serial transfer end
		logic pin;       // Input pin
		logic ext_timer; // Timer clocked from outside
		logic nmi;       // Non-maskable pin
	} lpr_irq_t;

	// True for mirrored registers that reset clears or loads
	function automatic logic lpr_is_reset(input logic [7:0] idx);
		case (idx)
			8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6, 8'hC8,
			8'hCC, 8'hCD, 8'hCE, 8'hD1, 8'hD2, 8'hD3, 8'hD4,
			8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hDA, 8'hDC, 8'hDD,
			8'hE0, 8'hE1, 8'hE2, 8'hEA: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Value loaded by reset into a mirrored register
	function automatic logic [7:0] lpr_reset_value(input logic [7:0] idx);
		case (idx)
			LPR_IDX_T1_COUNT: return LPR_RST_T1_COUNT;
			LPR_IDX_T1_PRESC: return LPR_RST_T1_PRESC;
			LPR_IDX_WDG_CNT:  return LPR_RST_WDG_CNT;
			LPR_IDX_ADC_CTRL: return LPR_RST_ADC_CTRL;
			default:          return LPR_RST_CLEAR;
		endcase
	endfunction

endpackage

`default_nettype wire

//--- hw/lpr_ctrl.sv
/*
 * Low-power sequencer and reset-state register mirror, with AXI4-Lite
 * slave. Assumes one clock, a synchronous active-high reset, core and
 * interrupt inputs synchronous to that clock, interrupt requests already
 * qualified by their enables, and a core that obeys the resume outputs.
 */
`default_nettype none

// Behaviour
// - Reset clears control, port, timer, serial registers
// - Clock undivided after reset, low-power bit zero
// - Ports pulled-up inputs, interrupts off, timers stopped
// - Serial off, not routed to port C3
// - Undefined registers untouched by reset, EEPROM control cleared
// - Timer counter max, prescaler reset value
// - Watchdog counter takes its reset value
// - Converter control resets to standby
// - Idle halts core, oscillator keeps running
// - Timer, converter, serial interrupts end idle
// - Idle wake resumes with no delay
// - Pin or watchdog reset in idle resets
// - Deep stop only with watchdog disabled
// - Deep stop stops oscillator until wake
// - Deep wake only by input pin, non-maskable pin or outside timer
// - Deep wake waits for oscillator settling
// - Reset pin ends deep stop, resets
// - From main, service routine runs first
// - From non-maskable, continue, stay non-maskable
// - Watchdog active turns deep into idle
// - Pending enabled request blocks both instructions
// - From interrupt routine, normal wake continues it
module lpr_ctrl
	import lpr_pkg::*;
#(
	parameter int P_STAB_CYCLES = LPR_STAB_CYCLES // Settling cycles
) (
	input  wire logic         i_clk_sys,       // 40 MHz clock
	input  wire logic         i_sys_rst,       // Synchronous reset
	input  wire logic         i_rst_pin_n,     // External reset pin
	input  wire logic         i_wdg_rst,       // Watchdog reset pulse
	input  wire logic         i_wdg_active,    // Watchdog running
	input  wire logic         i_idle_exec,     // Core runs idle
	input  wire logic         i_deep_exec,     // Core runs deep stop
	input  wire logic [1:0]   i_core_mode,     // Core mode at instruction
	input  wire logic         i_irq_pending,   // Enabled request pending
	input  wire lpr_irq_t     i_irq,           // Enabled wake requests
	input  wire lpr_axi_req_t i_axi,           // Bus requests
	output var  lpr_axi_rsp_t o_axi,           // Bus answers
	output logic              o_core_clk_en,   // Core clock gate
	output logic              o_osc_en,        // Oscillator enable
	output logic              o_core_rst,      // Core held in reset
	output logic              o_wake,          // Core resumes, pulse
	output logic              o_resume_service,// Run service first
	output logic [1:0]        o_resume_mode,   // Mode kept on resume
	output logic [1:0]        o_osc_div_sel,   // Clock divider select
	output logic              o_spi_to_pc3     // Serial on port C3
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		lpr_mode_t        mode;       // Sequencer state
		logic [1:0]       saved_mode; // Core mode at entry
		logic             by_nmi;     // Woken by non-maskable
		logic [11:0]      stab_cnt;   // Settling counter
		logic [12:0]      settle_seen; // Settling cycles, for checks
		logic             core_clk_en;
		logic             osc_en;
		logic             core_rst;
		logic             wake;
		logic             resume_srv;
		logic             deep_en;    // Software deep-stop permit
		logic [63:0][7:0] bank;       // Mirrored register set
		logic             aw_have;    // Write address captured
		logic [11:0]      aw_addr;
		logic             w_have;     // Write data captured
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		lpr_axi_rsp_t     axi;
	} lpr_regs_t;

	lpr_regs_t   st_q;          // Registered state
	lpr_regs_t   st_d;          // Next state
	logic        gen_rst;       // Any reset source
	logic        idle_wake;     // Wake in idle
	logic        deep_wake;     // Wake in deep stop
	logic [7:0]  w_idx;         // Write register index
	logic [7:0]  r_idx;         // Read register index

	localparam logic [11:0] STAB_LAST = 12'(P_STAB_CYCLES - 1);

	// Every reset source resets the sequencer and register set
	assign gen_rst   = i_sys_rst | ~i_rst_pin_n | i_wdg_rst;
	// Idle accepts every enabled source
	assign idle_wake = |i_irq;
	// Deep stop has no internal clock for peripherals
	assign deep_wake = i_irq.pin | i_irq.ext_timer | i_irq.nmi;
	assign w_idx     = st_q.aw_addr[9:2];
	assign r_idx     = i_axi.araddr[9:2];

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.wake = 1'b0;

		// Sequencer
		case (st_q.mode)
			LPR_RUN: begin
				// A pending request makes both instructions no-ops
				if (!i_irq_pending) begin
					if (i_idle_exec || (i_deep_exec &&
					    (i_wdg_active || !st_q.deep_en))) begin
						st_d.mode       = LPR_IDLE;
						st_d.saved_mode = i_core_mode;
					end else if (i_deep_exec) begin
						st_d.mode       = LPR_DEEP;
						st_d.saved_mode = i_core_mode;
					end
				end
			end
			LPR_IDLE: begin
				// Oscillator never stopped, so resume at once
				if (idle_wake) begin
					st_d.mode   = LPR_RUN;
					st_d.wake   = 1'b1;
					st_d.by_nmi = i_irq.nmi;
				end
			end
			LPR_DEEP: begin
				if (deep_wake) begin
					st_d.mode     = LPR_STAB;
					st_d.stab_cnt = 12'h000;
					st_d.by_nmi   = i_irq.nmi;
				end
			end
			LPR_STAB: begin
				// Core stays frozen until the oscillator settles
				if (st_q.stab_cnt == STAB_LAST) begin
					st_d.mode = LPR_RUN;
					st_d.wake = 1'b1;
				end else begin
					st_d.stab_cnt = st_q.stab_cnt + 12'h001;
				end
			end
			default: st_d.mode = LPR_RUN;
		endcase
		st_d.settle_seen = (st_q.mode == LPR_STAB && !gen_rst) ?
		    st_q.settle_seen + 13'h0001 : 13'h0000;

		// Main: service first; interrupt routine: only an NMI is
		// serviced first; non-maskable: continue in place
		st_d.resume_srv = (st_d.saved_mode == LPR_CORE_MAIN) ||
		    ((st_d.saved_mode == LPR_CORE_IRQ) && st_d.by_nmi);

		// Reset overrides the sequencer from any state
		st_d.core_rst = gen_rst;
		if (gen_rst) begin
			st_d.mode       = LPR_RUN;
			st_d.wake       = 1'b0;
			st_d.stab_cnt   = 12'h000;
			st_d.saved_mode = LPR_CORE_MAIN;
			st_d.by_nmi     = 1'b0;
			st_d.resume_srv = 1'b1;
		end

		// Clock gates follow the next state
		st_d.core_clk_en = (st_d.mode == LPR_RUN);
		st_d.osc_en      = (st_d.mode != LPR_DEEP);

		// AXI write channel: address and data taken in either order
		if (i_axi.awvalid && st_q.axi.awready) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = i_axi.awaddr;
		end
		if (i_axi.wvalid && st_q.axi.wready) begin
			st_d.w_have = 1'b1;
			st_d.w_data = i_axi.wdata;
			st_d.w_strb = i_axi.wstrb;
		end
		if (st_q.axi.bvalid && i_axi.bready) begin
			st_d.axi.bvalid = 1'b0;
		end
		if (st_q.aw_have && st_q.w_have && !st_q.axi.bvalid) begin
			st_d.aw_have    = 1'b0;
			st_d.w_have     = 1'b0;
			st_d.axi.bvalid = 1'b1;
			st_d.axi.bresp  = LPR_RESP_OKAY;
			// Registers are one byte wide, only lane 0 writes
			if (w_idx[7:6] == LPR_IDX_BANK[7:6]) begin
				if (st_q.w_strb[0]) begin
					st_d.bank[w_idx[5:0]] = st_q.w_data[7:0];
				end
			end else if (w_idx == LPR_IDX_CTRL) begin
				if (st_q.w_strb[0]) begin
					st_d.deep_en = st_q.w_data[LPR_CTRL_DEEP_EN];
				end
			end else if (w_idx != LPR_IDX_STAT) begin
				st_d.axi.bresp = LPR_RESP_SLVERR;
			end
		end
		st_d.axi.awready = !st_d.aw_have && !st_d.axi.bvalid;
		st_d.axi.wready  = !st_d.w_have && !st_d.axi.bvalid;

		// AXI read channel
		if (st_q.axi.rvalid && i_axi.rready) begin
			st_d.axi.rvalid = 1'b0;
		end
		if (i_axi.arvalid && st_q.axi.arready) begin
			st_d.axi.rvalid = 1'b1;
			st_d.axi.rresp  = LPR_RESP_OKAY;
			st_d.axi.rdata  = 32'h0000_0000;
			if (r_idx[7:6] == LPR_IDX_BANK[7:6]) begin
				st_d.axi.rdata[7:0] = st_q.bank[r_idx[5:0]];
			end else if (r_idx == LPR_IDX_CTRL) begin
				st_d.axi.rdata[LPR_CTRL_DEEP_EN] = st_q.deep_en;
			end else if (r_idx == LPR_IDX_STAT) begin
				st_d.axi.rdata[7:0] = {st_q.by_nmi, st_q.saved_mode,
				    st_q.core_rst, st_q.mode};
			end else begin
				st_d.axi.rresp = LPR_RESP_SLVERR;
			end
		end
		st_d.axi.arready = !st_d.axi.rvalid;

		// Reset loads the register set; undefined ones keep content
		if (gen_rst) begin
			for (int i = 0; i < 64; i++) begin
				if (lpr_is_reset(8'(LPR_IDX_BANK + i))) begin
					st_d.bank[i] = lpr_reset_value(
					    8'(LPR_IDX_BANK + i));
				end
			end
		end

		// Bus and local control only follow the system reset
		if (i_sys_rst) begin
			st_d.deep_en     = 1'b1;
			st_d.aw_have     = 1'b0;
			st_d.aw_addr     = 12'h000;
			st_d.w_have      = 1'b0;
			st_d.w_data      = 32'h0000_0000;
			st_d.w_strb      = 4'h0;
			st_d.axi         = '0;
			st_d.axi.awready = 1'b1;
			st_d.axi.wready  = 1'b1;
			st_d.axi.arready = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		st_q <= st_d;
	end

	// Outputs straight from flops
	assign o_axi            = st_q.axi;
	assign o_core_clk_en    = st_q.core_clk_en;
	assign o_osc_en         = st_q.osc_en;
	assign o_core_rst       = st_q.core_rst;
	assign o_wake           = st_q.wake;
	assign o_resume_service = st_q.resume_srv;
	assign o_resume_mode    = st_q.saved_mode;
	// Divider select zero means undivided clock
	assign o_osc_div_sel    = st_q.bank[LPR_IDX_OSC_CTRL[5:0]][1:0];
	assign o_spi_to_pc3     =
	    st_q.bank[LPR_IDX_MISC[5:0]][LPR_MISC_SPI_PC3];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_deep_wake;
		st_q.mode == LPR_DEEP && deep_wake && !gen_rst;
	endsequence

	sequence s_settle;
		!o_core_clk_en [*8];
	endsequence

	property p_rst_clear;
		@(posedge i_clk_sys) i_sys_rst |=>
		    st_q.bank[LPR_IDX_OSC_CTRL[5:0]] == 8'h00 &&
		    st_q.bank[LPR_IDX_EE_CTRL[5:0]] == 8'h00 &&
		    o_osc_div_sel == 2'h0 && !o_spi_to_pc3;
	endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("register set not cleared by reset");

	property p_rst_load;
		@(posedge i_clk_sys) i_sys_rst |=>
		    st_q.bank[LPR_IDX_T1_COUNT[5:0]] == 8'hFF &&
		    st_q.bank[LPR_IDX_T1_PRESC[5:0]] == 8'h7F &&
		    st_q.bank[LPR_IDX_WDG_CNT[5:0]] == 8'hFE &&
		    st_q.bank[LPR_IDX_ADC_CTRL[5:0]] == 8'h40;
	endproperty
	a_rst_load: assert property (p_rst_load)
		else $error("timer, watchdog or converter reset value wrong");

	property p_idle_entry;
		@(posedge i_clk_sys) disable iff (gen_rst)
		st_q.mode == LPR_RUN && i_idle_exec && !i_irq_pending |=>
		    !o_core_clk_en && o_osc_en;
	endproperty
	a_idle_entry: assert property (p_idle_entry)
		else $error("idle did not gate only the core clock");

	property p_idle_wake;
		@(posedge i_clk_sys) disable iff (gen_rst)
		st_q.mode == LPR_IDLE && idle_wake |=> o_core_clk_en && o_wake;
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("idle wake was delayed");

	property p_deep_settle;
		@(posedge i_clk_sys) disable iff (gen_rst)
		(s_deep_wake |=> s_settle) and
		(st_q.settle_seen <= 13'(P_STAB_CYCLES)) and
		(st_q.settle_seen != 13'h0000 && st_q.mode != LPR_STAB |->
		    o_wake && st_q.settle_seen == 13'(P_STAB_CYCLES));
	endproperty
	a_deep_settle: assert property (p_deep_settle)
		else $error("deep wake skipped or overran settling");

	property p_deep_osc_off;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		st_q.mode == LPR_DEEP |-> !o_osc_en && !o_core_clk_en;
	endproperty
	a_deep_osc_off: assert property (p_deep_osc_off)
		else $error("oscillator running in deep stop");

	property p_wdg_blocks_deep;
		@(posedge i_clk_sys) disable iff (gen_rst)
		st_q.mode == LPR_RUN && i_deep_exec && i_wdg_active &&
		    !i_irq_pending |=> st_q.mode == LPR_IDLE && o_osc_en;
	endproperty
	a_wdg_blocks_deep: assert property (p_wdg_blocks_deep)
		else $error("deep stop entered with watchdog active");

	property p_pending_blocks;
		@(posedge i_clk_sys) disable iff (gen_rst)
		st_q.mode == LPR_RUN && i_irq_pending |=> o_core_clk_en;
	endproperty
	a_pending_blocks: assert property (p_pending_blocks)
		else $error("low-power entered with request pending");

	property p_pin_reset;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_rst_pin_n |=> o_core_rst && o_osc_en && st_q.mode == LPR_RUN;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("reset pin did not run reset procedure");

	property p_nmi_resume;
		@(posedge i_clk_sys) disable iff (gen_rst)
		o_wake && o_resume_mode == LPR_CORE_NMI |-> !o_resume_service;
	endproperty
	a_nmi_resume: assert property (p_nmi_resume)
		else $error("non-maskable resume asked for service");

endmodule

`default_nettype wire

//--- tb/lpr_core_model.sv
/*
 * Behavioural model of the core and of the enabled wake sources.
 * Assumes the bench calls its tasks and drives nothing it owns.
 */
`default_nettype none

module lpr_core_model
	import lpr_pkg::*;
(
	input  wire logic    i_clk_sys,     // 40 MHz clock
	input  wire logic    i_wake,        // Core resumes
	output logic         o_idle_exec,   // Idle instruction pulse
	output logic         o_deep_exec,   // Deep-stop instruction pulse
	output logic [1:0]   o_core_mode,   // Mode at the instruction
	output logic         o_irq_pending, // Request already pending
	output lpr_irq_t     o_irq          // Enabled wake requests
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// Quiet start
	// ------------------------------------------------------------------
	initial begin
		o_idle_exec   = 1'b0;
		o_deep_exec   = 1'b0;
		o_core_mode   = LPR_CORE_MAIN;
		o_irq_pending = 1'b0;
		o_irq         = '0;
	end

	// Requests are taken by the core at wake, so they drop there
	always @(posedge i_clk_sys) begin
		if (i_wake === 1'b1) begin
			o_irq <= '0;
		end
	end

	// One low-power instruction, optionally with a pending request
	task automatic exec(input logic deep, input logic [1:0] md,
		input logic pnd);
		@(posedge i_clk_sys);
		o_core_mode   <= md;
		o_irq_pending <= pnd;
		o_idle_exec   <= ~deep;
		o_deep_exec   <= deep;
		@(posedge i_clk_sys);
		o_idle_exec   <= 1'b0;
		o_deep_exec   <= 1'b0;
		o_irq_pending <= 1'b0;
	endtask

	// Raise a set of requests; held until the core wakes
	task automatic req(input lpr_irq_t v);
		@(posedge i_clk_sys);
		o_irq <= v;
	endtask
endmodule

`default_nettype wire

//--- tb/low_power_mode_and_reset_state_test.sv
/*
 * Self-checking bench of the low-power and reset-state controller.
 * Assumes the core model beside it and AXI4-Lite at byte address 4*idx.
 */
`default_nettype none

module low_power_mode_and_reset_state_test;
	import lpr_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	localparam int P = 9;           // Short settling keeps the run brief
	logic         clk, rst, pin_n, wdg_rst, wdg_act;
	lpr_axi_req_t req;              // Bus master side
	lpr_axi_rsp_t rsp;              // Bus slave answers
	logic         idle_x, deep_x, pend, cke, osc, crst, wake, rsv, pc3;
	logic [1:0]   cmode, rmode, div;
	lpr_irq_t     irq;
	int           errors, n_checks;

	lpr_ctrl #(.P_STAB_CYCLES(P)) u_lpr_ctrl (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_rst_pin_n(pin_n),
		.i_wdg_rst(wdg_rst), .i_wdg_active(wdg_act),
		.i_idle_exec(idle_x), .i_deep_exec(deep_x),
		.i_core_mode(cmode), .i_irq_pending(pend), .i_irq(irq),
		.i_axi(req), .o_axi(rsp), .o_core_clk_en(cke), .o_osc_en(osc),
		.o_core_rst(crst), .o_wake(wake), .o_resume_service(rsv),
		.o_resume_mode(rmode), .o_osc_div_sel(div), .o_spi_to_pc3(pc3));

	lpr_core_model u_lpr_core_model (
		.i_clk_sys(clk), .i_wake(wake), .o_idle_exec(idle_x),
		.o_deep_exec(deep_x), .o_core_mode(cmode),
		.o_irq_pending(pend), .o_irq(irq));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		req.awaddr  <= {2'h0, idx, 2'h0};
		req.wdata   <= {24'h000000, d};
		req.wstrb   <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		req.bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while ((req.awvalid && !rsp.awready) ||
			(req.wvalid && !rsp.wready));
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		#1;
	endtask

	task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		req.araddr  <= {2'h0, idx, 2'h0};
		req.arvalid <= 1'b1;
		req.rready  <= 1'b1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	// Edges from the request's sampling edge up to the wake pulse
	task automatic wait_wake(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (wake !== 1'b1 && n < 100);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_vals();
		logic [7:0]  ix[14] = '{8'hDC, 8'hEA, 8'hC0, 8'hC4, 8'hCC, 8'hC8,
			8'hD4, 8'hD5, 8'hDD, 8'hE0, 8'hD3, 8'hD2, 8'hD8, 8'hD1};
		logic [7:0]  ev[14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h7F, 8'hFE, 8'h40};
		logic [31:0] d;
		logic [1:0]  r;
		for (int k = 0; k < 14; k++) begin
			axi_rd(ix[k], d, r);
			chk("reset_value", d, {24'h000000, ev[k]});
		end
		chk("div_sel", div, 2'h0);
		chk("spi_pc3", pc3, 1'b0);
		axi_rd(8'h10, d, r);
		chk("unmapped", r, LPR_RESP_SLVERR);
	endtask

	// Writes undone by a watchdog reset taken while idle, undefined D0 kept
	task automatic t_wdg_reset();
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(8'hD0, 8'h5A);
		axi_wr(LPR_IDX_OSC_CTRL, 8'h0B);
		axi_wr(LPR_IDX_MISC, 8'h01);
		chk("div_set", div, 2'h3);
		chk("pc3_set", pc3, 1'b1);
		u_lpr_core_model.exec(1'b0, LPR_CORE_MAIN, 1'b0);
		@(posedge clk);
		wdg_rst <= 1'b1;
		@(posedge clk);
		wdg_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("core_clk_rst", cke, 1'b1);
		axi_rd(LPR_IDX_OSC_CTRL, d, r);
		chk("osc_ctrl", d, 32'h00000000);
		chk("div_rst", div, 2'h0);
		chk("pc3_rst", pc3, 1'b0);
		axi_rd(8'hD0, d, r);
		chk("kept_reg", d, 32'h0000005A);
	endtask

	// Each timer, converter and serial source, woken at once from main
	task automatic t_idle_src();
		int n;
		for (int k = 3; k < 7; k++) begin
			u_lpr_core_model.exec(1'b0, LPR_CORE_MAIN, 1'b0);
			#1;
			chk("idle_gate", cke, 1'b0);
			chk("idle_osc", osc, 1'b1);
			u_lpr_core_model.req(lpr_irq_t'(7'h01 << k));
			wait_wake(n);
			chk("idle_latency", n, 1);
			chk("idle_svc", rsv, 1'b1);
			chk("idle_clk", cke, 1'b1);
		end
	endtask

	task automatic t_pending();
		u_lpr_core_model.exec(1'b0, LPR_CORE_MAIN, 1'b1);
		#1;
		chk("pend_idle", cke, 1'b1);
		u_lpr_core_model.exec(1'b1, LPR_CORE_MAIN, 1'b1);
		#1;
		chk("pend_deep", osc, 1'b1);
	endtask

	// Deep stop while the watchdog runs acts as idle
	task automatic t_wdg_deep();
		int n;
		@(posedge clk);
		wdg_act <= 1'b1;
		u_lpr_core_model.exec(1'b1, LPR_CORE_MAIN, 1'b0);
		#1;
		chk("wdg_osc", osc, 1'b1);
		chk("wdg_gate", cke, 1'b0);
		u_lpr_core_model.req(7'h10);
		wait_wake(n);
		chk("wdg_latency", n, 1);
		@(posedge clk);
		wdg_act <= 1'b0;
	endtask

	// Deep stop from the non-maskable routine, timer ignored, pin wakes
	task automatic t_deep_wake();
		int n;
		logic [31:0] d;
		logic [1:0]  r;
		u_lpr_core_model.exec(1'b1, LPR_CORE_NMI, 1'b0);
		#1;
		chk("deep_osc", osc, 1'b0);
		u_lpr_core_model.req(7'h40);
		repeat (4) @(posedge clk);
		#1;
		chk("deep_timer", osc, 1'b0);
		chk("deep_halt", cke, 1'b0);
		axi_rd(LPR_IDX_STAT, d, r);
		chk("deep_state", d, 32'h00000044);
		u_lpr_core_model.req(7'h04);
		wait_wake(n);
		chk("deep_settle", n, P + 1);
		chk("nmi_svc", rsv, 1'b0);
		chk("nmi_mode", rmode, LPR_CORE_NMI);
	endtask

	task automatic t_irq_mode();
		int n;
		u_lpr_core_model.exec(1'b0, LPR_CORE_IRQ, 1'b0);
		u_lpr_core_model.req(7'h40);
		wait_wake(n);
		chk("irq_svc", rsv, 1'b0);
		chk("irq_mode", rmode, LPR_CORE_IRQ);
		u_lpr_core_model.exec(1'b0, LPR_CORE_IRQ, 1'b0);
		u_lpr_core_model.req(7'h01);
		wait_wake(n);
		chk("irq_nmi_svc", rsv, 1'b1);
	endtask

	task automatic t_deep_pin();
		u_lpr_core_model.exec(1'b1, LPR_CORE_MAIN, 1'b0);
		@(posedge clk);
		pin_n <= 1'b0;
		@(posedge clk);
		#1;
		chk("pin_osc", osc, 1'b1);
		chk("pin_core_rst", crst, 1'b1);
		@(posedge clk);
		pin_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("pin_release", crst, 1'b0);
	endtask

	// ------------------------------------------------------------------
	// Clock, run, verdict
	// ------------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Whole run is under two hundred cycles; this is far beyond it
	initial begin
		#200000;
		errors++;
		end_of_test();
	end

	initial begin
		errors   = 0;
		n_checks = 0;
		rst      = 1'b1;
		pin_n    = 1'b1;
		wdg_rst  = 1'b0;
		wdg_act  = 1'b0;
		req      = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset_vals();
		t_wdg_reset();
		t_idle_src();
		t_pending();
		t_wdg_deep();
		t_deep_wake();
		t_irq_mode();
		t_deep_pin();
		end_of_test();
	end
endmodule

`default_nettype wire
